// ### pkg/xbar_pkg.sv
// shared constants and types for the memory crossbar and its arbiters
package xbar_pkg;

  // masters
  localparam int NUM_MASTERS = 3;
  localparam int M_CORE      = 0;
  localparam int M_DMA       = 1;
  localparam int M_AES       = 2;

  // address space tag carried with every master request
  localparam logic [1:0] SP_CODE     = 2'h0;
  localparam logic [1:0] SP_DIRECT   = 2'h1;
  localparam logic [1:0] SP_INDIRECT = 2'h2;
  localparam logic [1:0] SP_XDATA    = 2'h3;

  // target sizes and address widths
  localparam int XRAM_BYTES  = 4096;
  localparam int IRAM_BYTES  = 256;
  localparam int XRAM_AW     = 12;
  localparam int IRAM_AW     = 8;
  localparam int SFR_AW      = 8;
  localparam int EXTRA_XSPACE_REGS_AW     = 12;
  localparam int FLASH_WAW   = 15;
  localparam int CACHE_WORDS = 4;
  localparam int CACHE_IW    = 2;

  // internal data space split between registers and ram
  localparam logic [7:0] IDATA_UPPER = 8'h80;

  // external data space map, 4 kbyte granules except the flash window and the 256 byte register page
  localparam logic [3:0]  X_XRAM0_PAGE = 4'h0;
  localparam logic [3:0]  X_XRAM1_PAGE = 4'h1;
  localparam logic [3:0]  X_EXTRA_XSPACE_REGS_PAGE  = 4'h3;
  localparam logic [7:0]  X_SFR_PAGE   = 8'h70;
  localparam logic [15:0] X_FLASH_BASE = 16'h8000;

  typedef enum logic [2:0] {T_XRAM0, T_XRAM1, T_IRAM, T_FLASH, T_SFR, T_EXTRA_XSPACE_REGS, T_NONE} target_e;
  localparam int NUM_TARGETS = 6;

  typedef enum logic {FL_IDLE, FL_FILL} fill_state_e;

endpackage

// ### rtl/rr_arbiter.sv
// round-robin arbiter used once per bus target
`timescale 1ns/1ps
`default_nettype none
module rr_arbiter
#(
  parameter int N = 3
)
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // requests and grant
  input  wire logic [N-1:0] req,
  input  wire logic         advance,
  output logic      [N-1:0] grant
);

  localparam int W = (N > 1) ? $clog2(N) : 1;
  localparam logic [W-1:0] LAST_RESET = W'(N - 1);

  logic [W-1:0] last;
  logic [W-1:0] next_last;

  always_comb
  begin
    int         idx;
    logic       found;
    logic [W-1:0] pick;
    idx   = 0;
    found = 1'b0;
    pick  = last;
    grant = '0;
    // search starts just after the last served master, so none waits more than N-1 turns
    for (int k = 1; k <= N; k++)
    begin
      idx = (int'(last) + k) % N;
      if (!found && req[idx])
      begin
        grant[idx] = 1'b1;
        found      = 1'b1;
        pick       = W'(idx);
      end
    end
    // pointer only moves when the granted access really completes
    next_last = (advance && found) ? pick : last;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      last <= LAST_RESET;
    else
      last <= next_last;
  end

endmodule
`default_nettype wire

// ### rtl/memory_crossbar_arbiter.sv
// parallel memory crossbar joining three masters to ram, flash cache and register targets
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - three masters: core, dma, encryption engine
// - two 4 kbyte xram blocks, parallel access
// - 256 byte internal ram, always retained
// - 64 kbyte flash is an arbitrated target
// - direct accesses at 0x80 and above reach special function registers
// - upper flash half readable via xdata
// - special function registers mapped into xdata
// - four word cache plus prefetch
// - masters hit different targets each cycle
// - one arbiter per target
// - arbitration never starves a master
// - each xram block retained or off independently
// - encryption engine moves 16 bits per access
// - upper idata: direct to registers, indirect ram
module memory_crossbar_arbiter
  import xbar_pkg::*;
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // master requests, index 0 core, 1 dma, 2 encryption
  input  wire logic [NUM_MASTERS-1:0]    m_req,
  input  wire logic [1:0]                m_space [NUM_MASTERS],
  input  wire logic [15:0]               m_addr  [NUM_MASTERS],
  input  wire logic [NUM_MASTERS-1:0]    m_we,
  input  wire logic [1:0]                m_be    [NUM_MASTERS],
  input  wire logic [15:0]               m_wdata [NUM_MASTERS],
  // master answers
  output logic      [NUM_MASTERS-1:0]    m_wait,
  output logic      [NUM_MASTERS-1:0]    m_rvalid,
  output logic      [15:0]               m_rdata [NUM_MASTERS],
  // special function register target
  output logic                           sfr_sel,
  output logic      [SFR_AW-1:0]         sfr_addr,
  output logic                           sfr_we,
  output logic      [1:0]                sfr_be,
  output logic      [15:0]               sfr_wdata,
  input  wire logic [15:0]               sfr_rdata,
  // extra xspace register target
  output logic                           extra_xspace_regs_sel,
  output logic      [EXTRA_XSPACE_REGS_AW-1:0]        extra_xspace_regs_addr,
  output logic                           extra_xspace_regs_we,
  output logic      [1:0]                extra_xspace_regs_be,
  output logic      [15:0]               extra_xspace_regs_wdata,
  input  wire logic [15:0]               extra_xspace_regs_rdata,
  // flash array word port
  output logic                           flash_req,
  output logic      [FLASH_WAW-1:0]      flash_addr,
  input  wire logic                      flash_rvalid,
  input  wire logic [15:0]               flash_rdata,
  // sleep control
  input  wire logic                      sleep,
  input  wire logic [1:0]                xram_retain,
  output logic      [1:0]                xram_power_en
);

  function automatic target_e decode(input logic [1:0] sp, input logic [15:0] a);
    target_e t;
    t = T_NONE;
    case (sp)
      SP_CODE:     t = T_FLASH;
      SP_DIRECT:   t = (a[7:0] >= IDATA_UPPER) ? T_SFR : T_IRAM;
      SP_INDIRECT: t = T_IRAM;
      SP_XDATA:
      begin
        if (a >= X_FLASH_BASE)
          t = T_FLASH;
        else if (a[15:8] == X_SFR_PAGE)
          t = T_SFR;
        else if (a[15:12] == X_EXTRA_XSPACE_REGS_PAGE)
          t = T_EXTRA_XSPACE_REGS;
        else if (a[15:12] == X_XRAM1_PAGE)
          t = T_XRAM1;
        else if (a[15:12] == X_XRAM0_PAGE)
          t = T_XRAM0;
        else
          t = T_NONE;
      end
      default:     t = T_NONE;
    endcase
    return t;
  endfunction

  function automatic logic [1:0] onehot_idx(input logic [NUM_MASTERS-1:0] g);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 0; k < NUM_MASTERS; k++)
    begin
      if (g[k])
        r = 2'(k);
    end
    return r;
  endfunction

  // storage
  logic [7:0] xram0 [XRAM_BYTES];
  logic [7:0] xram1 [XRAM_BYTES];
  logic [7:0] iram  [IRAM_BYTES];

  target_e              tsel [NUM_MASTERS];
  logic [NUM_MASTERS-1:0] treq [NUM_TARGETS];
  logic [NUM_MASTERS-1:0] tgnt [NUM_TARGETS];
  logic [NUM_TARGETS-1:0] tadv;
  logic [1:0]           gsfr;
  logic [1:0]           gxreg;
  logic [1:0]           gflash;
  logic [NUM_MASTERS-1:0] done;

  // flash cache state
  fill_state_e          fl_state;
  fill_state_e          next_fl_state;
  logic [FLASH_WAW-1:0] fl_word;
  logic [FLASH_WAW-1:0] next_fl_word;
  logic [FLASH_WAW-1:0] pf_word;
  logic [FLASH_WAW-1:0] next_pf_word;
  logic                 pf_pend;
  logic                 next_pf_pend;
  logic [CACHE_WORDS-1:0] cv;
  logic [CACHE_WORDS-1:0] next_cv;
  logic [FLASH_WAW-1:0] ctag       [CACHE_WORDS];
  logic [FLASH_WAW-1:0] next_ctag  [CACHE_WORDS];
  logic [15:0]          cdata      [CACHE_WORDS];
  logic [15:0]          next_cdata [CACHE_WORDS];
  logic [CACHE_IW-1:0]  repl;
  logic [CACHE_IW-1:0]  next_repl;
  logic [FLASH_WAW-1:0] want_word;
  logic                 flash_hit;
  logic [15:0]          hit_data;
  logic                 pf_cached;

  // answer and power state
  logic [1:0]           xram_on;
  logic [1:0]           next_xram_on;
  logic [NUM_MASTERS-1:0] next_m_rvalid;
  logic [15:0]          next_m_rdata [NUM_MASTERS];

  // each master is steered to one target, all targets work in parallel
  always_comb
  begin
    for (int t = 0; t < NUM_TARGETS; t++)
      treq[t] = '0;
    for (int m = 0; m < NUM_MASTERS; m++)
    begin
      tsel[m] = decode(m_space[m], m_addr[m]);
      if (tsel[m] != T_NONE)
        treq[int'(tsel[m])][m] = m_req[m];
    end
  end

  for (genvar t = 0; t < NUM_TARGETS; t++)
  begin : g_arb
    rr_arbiter #(.N(NUM_MASTERS)) u_arb
    (
      .clock   (clock),
      .rst_n   (rst_n),
      .req     (treq[t]),
      .advance (tadv[t]),
      .grant   (tgnt[t])
    );
    // flash only completes on a cache hit; other targets finish in the grant cycle
    assign tadv[t] = (|tgnt[t]) && ((t != int'(T_FLASH)) || flash_hit);
  end

  assign gsfr   = onehot_idx(tgnt[int'(T_SFR)]);
  assign gxreg  = onehot_idx(tgnt[int'(T_EXTRA_XSPACE_REGS)]);
  assign gflash = onehot_idx(tgnt[int'(T_FLASH)]);

  always_comb
  begin
    for (int m = 0; m < NUM_MASTERS; m++)
    begin
      if (tsel[m] == T_NONE)
        done[m] = m_req[m];
      else
        done[m] = m_req[m] && tgnt[int'(tsel[m])][m] && tadv[int'(tsel[m])];
    end
  end

  assign m_wait = m_req & ~done;

  // register targets take the granted master's cycle straight through
  assign sfr_sel    = |tgnt[int'(T_SFR)];
  assign sfr_addr   = m_addr[gsfr][SFR_AW-1:0];
  assign sfr_we     = sfr_sel && m_we[gsfr];
  assign sfr_be     = m_be[gsfr];
  assign sfr_wdata  = m_wdata[gsfr];
  assign extra_xspace_regs_sel   = |tgnt[int'(T_EXTRA_XSPACE_REGS)];
  assign extra_xspace_regs_addr  = m_addr[gxreg][EXTRA_XSPACE_REGS_AW-1:0];
  assign extra_xspace_regs_we    = extra_xspace_regs_sel && m_we[gxreg];
  assign extra_xspace_regs_be    = m_be[gxreg];
  assign extra_xspace_regs_wdata = m_wdata[gxreg];

  // cache lookup for the granted flash master and for the prefetch candidate
  always_comb
  begin
    want_word = m_addr[gflash][15:1];
    flash_hit = 1'b0;
    hit_data  = 16'h0000;
    pf_cached = 1'b0;
    for (int e = 0; e < CACHE_WORDS; e++)
    begin
      if (cv[e] && ctag[e] == want_word)
      begin
        flash_hit = |tgnt[int'(T_FLASH)];
        hit_data  = cdata[e];
      end
      if (cv[e] && ctag[e] == pf_word)
        pf_cached = 1'b1;
    end
  end

  // demand fills take priority; after each fill the next word is prefetched
  always_comb
  begin
    next_fl_state = fl_state;
    next_fl_word  = fl_word;
    next_pf_word  = pf_word;
    next_pf_pend  = pf_pend;
    next_cv       = cv;
    next_ctag     = ctag;
    next_cdata    = cdata;
    next_repl     = repl;
    case (fl_state)
      FL_IDLE:
      begin
        if ((|tgnt[int'(T_FLASH)]) && !flash_hit)
        begin
          next_fl_state = FL_FILL;
          next_fl_word  = want_word;
          next_pf_pend  = 1'b0;
        end
        else if (pf_pend)
        begin
          next_pf_pend = 1'b0;
          if (!pf_cached)
          begin
            next_fl_state = FL_FILL;
            next_fl_word  = pf_word;
          end
        end
      end
      FL_FILL:
      begin
        if (flash_rvalid)
        begin
          next_cv[repl]    = 1'b1;
          next_ctag[repl]  = fl_word;
          next_cdata[repl] = flash_rdata;
          next_repl        = repl + 1'b1;
          next_pf_word     = fl_word + 1'b1;
          next_pf_pend     = 1'b1;
          next_fl_state    = FL_IDLE;
        end
      end
      default: next_fl_state = FL_IDLE;
    endcase
  end

  assign flash_req  = (fl_state == FL_FILL);
  assign flash_addr = fl_word;

  // read answers; a powered-off xram block reads zero and drops writes
  always_comb
  begin
    logic [XRAM_AW-1:0] xa;
    logic [XRAM_AW-1:0] xb;
    logic [IRAM_AW-1:0] ia;
    logic [IRAM_AW-1:0] ib;
    xa = '0;
    xb = '0;
    ia = '0;
    ib = '0;
    for (int m = 0; m < NUM_MASTERS; m++)
    begin
      xa = m_addr[m][XRAM_AW-1:0];
      xb = xa + 1'b1;
      ia = m_addr[m][IRAM_AW-1:0];
      ib = ia + 1'b1;
      next_m_rvalid[m] = done[m] && !m_we[m];
      next_m_rdata[m]  = m_rdata[m];
      if (done[m] && !m_we[m])
      begin
        case (tsel[m])
          T_XRAM0: next_m_rdata[m] = xram_on[0] ? {xram0[xb], xram0[xa]} : 16'h0000;
          T_XRAM1: next_m_rdata[m] = xram_on[1] ? {xram1[xb], xram1[xa]} : 16'h0000;
          T_IRAM:  next_m_rdata[m] = {iram[ib], iram[ia]};
          T_FLASH: next_m_rdata[m] = m_addr[m][0] ? {8'h00, hit_data[15:8]} : hit_data;
          T_SFR:   next_m_rdata[m] = sfr_rdata;
          T_EXTRA_XSPACE_REGS:  next_m_rdata[m] = extra_xspace_regs_rdata;
          default: next_m_rdata[m] = 16'h0000;
        endcase
      end
    end
  end

  assign next_xram_on  = ~({2{sleep}} & ~xram_retain);
  assign xram_power_en = xram_on;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fl_state <= FL_IDLE;
      fl_word  <= '0;
      pf_word  <= '0;
      pf_pend  <= 1'b0;
      cv       <= '0;
      repl     <= '0;
      xram_on  <= 2'h3;
      m_rvalid <= '0;
      for (int e = 0; e < CACHE_WORDS; e++)
      begin
        ctag[e]  <= '0;
        cdata[e] <= 16'h0000;
      end
      for (int m = 0; m < NUM_MASTERS; m++)
        m_rdata[m] <= 16'h0000;
    end
    else
    begin
      fl_state <= next_fl_state;
      fl_word  <= next_fl_word;
      pf_word  <= next_pf_word;
      pf_pend  <= next_pf_pend;
      cv       <= next_cv;
      ctag     <= next_ctag;
      cdata    <= next_cdata;
      repl     <= next_repl;
      xram_on  <= next_xram_on;
      m_rvalid <= next_m_rvalid;
      m_rdata  <= next_m_rdata;
    end
  end

  // memories have no reset; ram contents are undefined after power-up anyway
  always_ff @(posedge clock)
  begin
    for (int m = 0; m < NUM_MASTERS; m++)
    begin
      if (done[m] && m_we[m])
      begin
        case (tsel[m])
          T_XRAM0:
          begin
            if (xram_on[0] && m_be[m][0])
              xram0[m_addr[m][XRAM_AW-1:0]] <= m_wdata[m][7:0];
            if (xram_on[0] && m_be[m][1])
              xram0[XRAM_AW'(m_addr[m][XRAM_AW-1:0] + 1'b1)] <= m_wdata[m][15:8];
          end
          T_XRAM1:
          begin
            if (xram_on[1] && m_be[m][0])
              xram1[m_addr[m][XRAM_AW-1:0]] <= m_wdata[m][7:0];
            if (xram_on[1] && m_be[m][1])
              xram1[XRAM_AW'(m_addr[m][XRAM_AW-1:0] + 1'b1)] <= m_wdata[m][15:8];
          end
          T_IRAM:
          begin
            if (m_be[m][0])
              iram[m_addr[m][IRAM_AW-1:0]] <= m_wdata[m][7:0];
            if (m_be[m][1])
              iram[IRAM_AW'(m_addr[m][IRAM_AW-1:0] + 1'b1)] <= m_wdata[m][15:8];
          end
          default: ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/xbar_checker_asserts.sv
// concurrent checks on the crossbar master and target ports
`timescale 1ns/1ps
`default_nettype none
module xbar_checker
  import xbar_pkg::*;
(
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rst_n,
  // master side
  input wire logic [NUM_MASTERS-1:0] m_req,
  input wire logic [1:0]             m_space [NUM_MASTERS],
  input wire logic [15:0]            m_addr  [NUM_MASTERS],
  input wire logic [NUM_MASTERS-1:0] m_we,
  input wire logic [NUM_MASTERS-1:0] m_wait,
  input wire logic [NUM_MASTERS-1:0] m_rvalid,
  // register targets and sleep
  input wire logic                   sfr_sel,
  input wire logic [SFR_AW-1:0]      sfr_addr,
  input wire logic                   extra_xspace_regs_sel,
  input wire logic [EXTRA_XSPACE_REGS_AW-1:0]     extra_xspace_regs_addr,
  input wire logic                   sleep,
  input wire logic [1:0]             xram_retain,
  input wire logic [1:0]             xram_power_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [NUM_MASTERS-1:0] done;
  logic [NUM_MASTERS-1:0] hit0;
  logic [NUM_MASTERS-1:0] hit1;
  always_comb
    for (int i = 0; i < NUM_MASTERS; i++)
    begin
      done[i] = m_req[i] && !m_wait[i];
      hit0[i] = m_space[i] == SP_XDATA && m_addr[i][15:12] == X_XRAM0_PAGE;
      hit1[i] = m_space[i] == SP_XDATA && m_addr[i][15:12] == X_XRAM1_PAGE;
    end
  for (genvar i = 0; i < NUM_MASTERS; i++)
  begin : g_m
    sequence read_done;
      m_req[i] && !m_wait[i] && !m_we[i];
    endsequence
    sequence stuck_xram;
      m_req[i] && m_wait[i] && (hit0[i] || hit1[i]);
    endsequence
    read_answer_a: assert property (read_done |=> m_rvalid[i]) else $error("read not answered");
    rvalid_cause_a: assert property (m_rvalid[i] |-> $past(m_req[i] && !m_wait[i] && !m_we[i]))
      else $error("rvalid without read");
    idle_wait_a: assert property (!m_req[i] |-> !m_wait[i]) else $error("wait without request");
    no_starve_a: assert property (stuck_xram [*2] |=> !m_wait[i]) else $error("master starved");
    sfr_direct_a: assert property (done[i] && m_space[i] == SP_DIRECT && m_addr[i][7:0] >= IDATA_UPPER
      |-> sfr_sel && sfr_addr == m_addr[i][7:0]) else $error("direct access missed registers");
    sfr_xdata_a: assert property (done[i] && m_space[i] == SP_XDATA && m_addr[i][15:8] == X_SFR_PAGE
      |-> sfr_sel && sfr_addr == m_addr[i][7:0]) else $error("xdata register access lost");
    extra_xspace_regs_route_a: assert property (done[i] && m_space[i] == SP_XDATA && m_addr[i][15:12] == X_EXTRA_XSPACE_REGS_PAGE
      |-> extra_xspace_regs_sel && extra_xspace_regs_addr == m_addr[i][11:0]) else $error("extra_xspace_regs access lost");
  end
  one_grant_a: assert property ($onehot0(done & hit0) && $onehot0(done & hit1))
    else $error("two grants on one ram");
  solo_grant_a: assert property ($onehot(m_req) && |(m_req & (hit0 | hit1)) |-> m_wait == '0)
    else $error("uncontended request waited");
  parallel_a: assert property (m_req[M_CORE] && m_req[M_DMA] && hit0[M_CORE] && hit1[M_DMA]
    && !(m_req[M_AES] && (hit0[M_AES] || hit1[M_AES])) |-> !m_wait[M_CORE] && !m_wait[M_DMA])
    else $error("parallel rams serialised");
  power_a: assert property (xram_power_en == ~({2{$past(sleep)}} & ~$past(xram_retain)))
    else $error("ram power state wrong");
endmodule
bind memory_crossbar_arbiter xbar_checker u_chk (.clock, .rst_n, .m_req, .m_space, .m_addr, .m_we, .m_wait,
  .m_rvalid, .sfr_sel, .sfr_addr, .extra_xspace_regs_sel, .extra_xspace_regs_addr, .sleep, .xram_retain, .xram_power_en);
`default_nettype wire

// ### dv/target_model.sv
// flash array and register file responders on the target side
`timescale 1ns/1ps
`default_nettype none
module target_model
  import xbar_pkg::*;
#(
  parameter int LAT = 3
)
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // flash word port
  input  wire logic                 flash_req,
  input  wire logic [FLASH_WAW-1:0] flash_addr,
  output logic                      flash_rvalid,
  output logic      [15:0]          flash_rdata,
  // register targets
  input  wire logic                 sfr_sel,
  input  wire logic [SFR_AW-1:0]    sfr_addr,
  output logic      [15:0]          sfr_rdata,
  input  wire logic                 extra_xspace_regs_sel,
  input  wire logic [EXTRA_XSPACE_REGS_AW-1:0]   extra_xspace_regs_addr,
  output logic      [15:0]          extra_xspace_regs_rdata
);
  logic [3:0]           cnt;
  logic [FLASH_WAW-1:0] a_q;
  logic [15:0]          noise;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      cnt          <= 4'h0;
      flash_rvalid <= 1'b0;
      a_q          <= '0;
      noise        <= 16'h0000;
    end
    else
    begin
      noise        <= noise + 16'h3b5d;
      flash_rvalid <= 1'b0;
      a_q          <= flash_addr;
      // a changed address is a cancelled fetch, so the slow access starts over
      if (!flash_req || flash_rvalid || flash_addr != a_q)
        cnt <= 4'h0;
      else if (cnt == 4'(LAT))
        flash_rvalid <= 1'b1;
      else
        cnt <= cnt + 4'h1;
    end
  // idle data lines never repeat the last word
  assign flash_rdata = flash_rvalid ? {a_q[7:0] ^ 8'h5a, a_q[7:0]} : noise;
  assign sfr_rdata   = sfr_sel ? {sfr_addr, ~sfr_addr} : ~noise;
  assign extra_xspace_regs_rdata  = extra_xspace_regs_sel ? {extra_xspace_regs_addr[7:0], ~extra_xspace_regs_addr[7:0]} : noise;
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the memory crossbar
`timescale 1ns/1ps
`default_nettype none
module tb;
  import xbar_pkg::*;
  logic                   clock, rst_n, sleep, sfr_sel, sfr_we, extra_xspace_regs_sel, extra_xspace_regs_we, flash_req, flash_rvalid;
  logic [NUM_MASTERS-1:0] m_req, m_we, m_wait, m_rvalid;
  logic [1:0]             m_space [NUM_MASTERS];
  logic [1:0]             m_be    [NUM_MASTERS];
  logic [15:0]            m_addr  [NUM_MASTERS];
  logic [15:0]            m_wdata [NUM_MASTERS];
  logic [15:0]            m_rdata [NUM_MASTERS];
  logic [1:0]             xram_retain, xram_power_en, sfr_be, extra_xspace_regs_be;
  logic [SFR_AW-1:0]      sfr_addr;
  logic [EXTRA_XSPACE_REGS_AW-1:0]     extra_xspace_regs_addr;
  logic [FLASH_WAW-1:0]   flash_addr;
  logic [15:0]            sfr_wdata, sfr_rdata, extra_xspace_regs_wdata, extra_xspace_regs_rdata, flash_rdata, rd;
  int                     mismatches, n_checks;

  memory_crossbar_arbiter uut (.clock, .rst_n, .m_req, .m_space, .m_addr, .m_we, .m_be, .m_wdata, .m_wait,
    .m_rvalid, .m_rdata, .sfr_sel, .sfr_addr, .sfr_we, .sfr_be, .sfr_wdata, .sfr_rdata, .extra_xspace_regs_sel, .extra_xspace_regs_addr,
    .extra_xspace_regs_we, .extra_xspace_regs_be, .extra_xspace_regs_wdata, .extra_xspace_regs_rdata, .flash_req, .flash_addr, .flash_rvalid, .flash_rdata,
    .sleep, .xram_retain, .xram_power_en);
  target_model u_tgt (.clock, .rst_n, .flash_req, .flash_addr, .flash_rvalid, .flash_rdata, .sfr_sel,
    .sfr_addr, .sfr_rdata, .extra_xspace_regs_sel, .extra_xspace_regs_addr, .extra_xspace_regs_rdata);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic set(input int m, input logic [1:0] sp, input logic [15:0] a, input logic we,
                     input logic [15:0] wd);
    m_req[m]   = 1'b1;
    m_space[m] = sp;
    m_addr[m]  = a;
    m_we[m]    = we;
    m_wdata[m] = wd;
  endtask

  // one full transfer; request held until the edge that completes it
  task automatic acc(input int m, input logic [1:0] sp, input logic [15:0] a, input logic we,
                     input logic [15:0] wd);
    int n;
    @(posedge clock);
    #1;
    set(m, sp, a, we, wd);
    // wait is combinational, so let it settle before the first look
    #1;
    n = 0;
    while (m_wait[m] !== 1'b0 && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("grant", 16'h0000, {15'h0, m_wait[m]});
    @(posedge clock);
    #1;
    m_req[m] = 1'b0;
    rd = m_rdata[m];
    if (!we) chk("rvalid", 16'h0001, {15'h0, m_rvalid[m]});
  endtask

  task automatic t_par;
    set(M_CORE, SP_XDATA, 16'h0010, 1'b1, 16'h1234);
    set(M_DMA, SP_XDATA, 16'h1020, 1'b1, 16'h5678);
    set(M_AES, SP_INDIRECT, 16'h0090, 1'b1, 16'h9abc);
    #1;
    chk("par_wait", 16'h0000, {13'h0, m_wait});
    @(posedge clock);
    #1;
    m_req = '0;
    acc(M_DMA, SP_XDATA, 16'h0010, 1'b0, 16'h0000);
    chk("xram0", 16'h1234, rd);
    acc(M_CORE, SP_XDATA, 16'h1020, 1'b0, 16'h0000);
    chk("xram1", 16'h5678, rd);
    acc(M_CORE, SP_INDIRECT, 16'h0090, 1'b0, 16'h0000);
    chk("iram_upper", 16'h9abc, rd);
    acc(M_CORE, SP_DIRECT, 16'h0090, 1'b0, 16'h0000);
    chk("sfr_direct", 16'h906f, rd);
    acc(M_DMA, SP_DIRECT, 16'h0010, 1'b1, 16'h4321);
    acc(M_AES, SP_INDIRECT, 16'h0010, 1'b0, 16'h0000);
    chk("iram_lower", 16'h4321, rd);
    acc(M_DMA, SP_XDATA, 16'h7090, 1'b0, 16'h0000);
    chk("sfr_xdata", 16'h906f, rd);
    acc(M_AES, SP_XDATA, 16'h3004, 1'b0, 16'h0000);
    chk("extra_xspace_regs", 16'h04fb, rd);
    acc(M_CORE, SP_XDATA, 16'h2000, 1'b0, 16'h0000);
    chk("unmapped", 16'h0000, rd);
  endtask

  // register writes from two masters in one cycle, straight through to both targets
  task automatic t_regw;
    @(posedge clock);
    #1;
    m_be[M_DMA] = 2'b10;
    set(M_CORE, SP_DIRECT, 16'h0085, 1'b1, 16'hbeef);
    set(M_DMA, SP_XDATA, 16'h3123, 1'b1, 16'h5a5a);
    #1;
    chk("sfr_we", 16'h0001, {15'h0, sfr_we});
    chk("sfr_be", 16'h0003, {14'h0, sfr_be});
    chk("sfr_wdata", 16'hbeef, sfr_wdata);
    chk("extra_xspace_regs_we", 16'h0001, {15'h0, extra_xspace_regs_we});
    chk("extra_xspace_regs_be", 16'h0002, {14'h0, extra_xspace_regs_be});
    chk("extra_xspace_regs_addr", 16'h0123, {4'h0, extra_xspace_regs_addr});
    chk("extra_xspace_regs_wdata", 16'h5a5a, extra_xspace_regs_wdata);
    @(posedge clock);
    #1;
    m_req       = '0;
    m_be[M_DMA] = 2'b11;
    #1;
    chk("sfr_idle", 16'h0000, {14'h0, sfr_sel, sfr_we});
  endtask

  // all masked masters read one ram at once; one grant per cycle, none left over
  task automatic t_race(input logic [2:0] mask);
    logic [2:0] done;
    @(posedge clock);
    #1;
    for (int i = 0; i < NUM_MASTERS; i++)
      if (mask[i]) set(i, SP_XDATA, 16'h1020, 1'b0, 16'h0000);
    repeat (3)
    begin
      #1;
      done = m_req & ~m_wait;
      chk("one_grant", {15'h0, m_req != 3'b000}, 16'($countones(done)));
      @(posedge clock);
      #1;
      for (int i = 0; i < NUM_MASTERS; i++)
        if (done[i]) chk("race_data", 16'h5678, m_rdata[i]);
      m_req = m_req & ~done;
    end
    chk("starved", 16'h0000, {13'h0, m_req});
  endtask

  task automatic t_flash;
    acc(M_CORE, SP_CODE, 16'h0100, 1'b0, 16'h0000);
    chk("code", 16'hda80, rd);
    acc(M_DMA, SP_XDATA, 16'h8102, 1'b0, 16'h0000);
    chk("flash_xdata", 16'hdb81, rd);
    acc(M_CORE, SP_CODE, 16'h0103, 1'b0, 16'h0000);
    chk("code_odd", 16'h00db, rd);
    @(posedge clock);
    #1;
    set(M_AES, SP_CODE, 16'h0100, 1'b0, 16'h0000);
    #1;
    chk("hit_wait", 16'h0000, {15'h0, m_wait[M_AES]});
    @(posedge clock);
    #1;
    m_req = '0;
    chk("hit_data", 16'hda80, m_rdata[M_AES]);
  endtask

  task automatic t_sleep;
    sleep       = 1'b1;
    xram_retain = 2'b01;
    @(posedge clock);
    #1;
    chk("power", 16'h0001, {14'h0, xram_power_en});
    acc(M_CORE, SP_XDATA, 16'h1020, 1'b0, 16'h0000);
    chk("off_read", 16'h0000, rd);
    acc(M_DMA, SP_XDATA, 16'h0010, 1'b0, 16'h0000);
    chk("kept_read", 16'h1234, rd);
    sleep       = 1'b0;
    xram_retain = 2'b11;
    @(posedge clock);
    #1;
    chk("power_on", 16'h0003, {14'h0, xram_power_en});
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    mismatches  = 0;
    n_checks    = 0;
    rst_n       = 1'b0;
    sleep       = 1'b0;
    xram_retain = 2'b11;
    m_req       = '0;
    m_we        = '0;
    for (int i = 0; i < NUM_MASTERS; i++)
    begin
      m_space[i] = SP_XDATA;
      m_addr[i]  = 16'h0000;
      m_be[i]    = 2'b11;
      m_wdata[i] = 16'h0000;
    end
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_par;
    t_regw;
    t_race(3'b011);
    t_race(3'b111);
    t_race(3'b110);
    t_flash;
    t_sleep;
    end_of_test;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
